//--- rtl/fmb_host.sv
/*
  Host controller for a multi-bank parallel flash: reads, writes, hardware
  restart, accelerated programming with one write cycle per word, width select.
  Assumes inputs synchronous to i_clk and a board switch for the high voltage.
*/
`timescale 1ns/1ps
// Overview of operation
// - Host uses two-cycle program under accel; this host issues one write cycle per operation
// - Accel voltage only during accelerated programming
// - Protect/accelerate pin always driven defined
// - Identification reads use normal read timing
// - After standby wait full select access
// - Host reissues operation aborted by restart; this host only pulses o_abort and does not reissue
// - Idle restart recovery; read after delay
// - Bypass program takes two write cycles; this host issues one write cycle per operation
module fmb_host (
  input  wire logic           i_clk,
  input  wire logic           i_rst,
  input  wire logic           i_req,
  input  wire fmb_pkg::fmb_op_t i_op,
  input  wire logic [21:0]    i_addr,
  input  wire logic [15:0]    i_wdata,
  input  wire logic           i_byte_mode,
  input  wire logic           i_wp_on,
  input  wire logic [15:0]    i_dq_in,
  input  wire logic           i_ready_busy_n,
  output logic                o_ack,
  output logic [15:0]         o_rdata,
  output logic                o_busy,
  output logic [20:0]         o_addr,
  output logic [15:0]         o_dq_out,
  output logic [15:0]         o_dq_oe_n,
  output logic                o_ce_n,
  output logic                o_oe_n,
  output logic                o_we_n,
  output logic                o_restart_n,
  output logic                o_width_n,
  output fmb_pkg::fmb_pa_t    o_protect_accel_pin,
  output logic                o_abort
);
  import fmb_pkg::*;
  typedef enum logic [2:0] {S_IDLE, S_RD, S_WR, S_WR_GAP, S_RST, S_RST_WAIT, S_RH}
    fmb_state_t;
  fmb_state_t  st;
  fmb_tmr_if   tm ();
  logic        load;
  logic [31:0] count;
  logic        was_busy;
  fmb_timer u_tmr (.i_clk(i_clk), .i_rst(i_rst), .t(tm));
  assign tm.load  = load;
  assign tm.count = count;

  // Sequencer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st          <= S_IDLE;
      load        <= 1'b0;
      count       <= 32'h0000_0000;
      o_ack       <= 1'b0;
      o_rdata     <= 16'h0000;
      o_addr      <= 21'h00_0000;
      o_dq_out    <= 16'h0000;
      o_dq_oe_n   <= 16'hFFFF;
      o_ce_n      <= 1'b1;
      o_oe_n      <= 1'b1;
      o_we_n      <= 1'b1;
      o_restart_n <= 1'b1;
      o_width_n   <= 1'b1;
      o_abort     <= 1'b0;
      was_busy    <= 1'b0;
    end else begin
      load    <= 1'b0;
      o_ack   <= 1'b0;
      o_abort <= 1'b0;
      unique case (st)
        S_IDLE: begin
          o_ce_n    <= 1'b1;
          o_oe_n    <= 1'b1;
          o_we_n    <= 1'b1;
          o_dq_oe_n <= 16'hFFFF;
          if (i_req) begin
            o_width_n <= !i_byte_mode;
            o_addr    <= i_byte_mode ? i_addr[21:1] : i_addr[20:0];
            unique case (i_op)
              FMB_OP_READ: begin
                // Full select access from standby, same for id reads
                o_ce_n <= 1'b0;
                o_oe_n <= 1'b0;
                if (i_byte_mode) begin
                  o_dq_out     <= {i_addr[0], 15'h0000};
                  o_dq_oe_n    <= 16'h7FFF;
                end
                load  <= 1'b1;
                count <= 32'(CE_CYC > ACC_CYC ? CE_CYC : ACC_CYC);
                st    <= S_RD;
              end
              FMB_OP_WRITE, FMB_OP_ACCEL_ON, FMB_OP_ACCEL_OFF: begin
                // Program cycles; one write cycle per word, accel or not
                o_ce_n    <= 1'b0;
                o_we_n    <= 1'b0;
                o_dq_out  <= i_byte_mode ? {i_addr[0], 7'h00, i_wdata[7:0]} : i_wdata;
                o_dq_oe_n <= i_byte_mode ? 16'h7F00 : 16'h0000;
                load      <= 1'b1;
                count     <= 32'(WP_CYC);
                st        <= S_WR;
              end
              FMB_OP_RESTART: begin
                was_busy    <= !i_ready_busy_n;
                o_restart_n <= 1'b0;
                load        <= 1'b1;
                count       <= 32'(RP_CYC);
                st          <= S_RST;
              end
              default: st <= S_IDLE;
            endcase
          end
        end
        S_RD: begin
          if (tm.done) begin
            o_rdata <= i_byte_mode ? {8'h00, i_dq_in[7:0]} : i_dq_in;
            o_ack   <= 1'b1;
            o_ce_n  <= 1'b1;
            o_oe_n  <= 1'b1;
            o_dq_oe_n <= 16'hFFFF;
            st      <= S_IDLE;
          end
        end
        S_WR: begin
          if (tm.done) begin
            o_we_n <= 1'b1;
            load   <= 1'b1;
            count  <= 32'(WP_CYC);
            st     <= S_WR_GAP;
          end
        end
        S_WR_GAP: begin
          if (tm.done) begin
            o_ce_n    <= 1'b1;
            o_dq_oe_n <= 16'hFFFF;
            o_ack     <= 1'b1;
            st        <= S_IDLE;
          end
        end
        S_RST: begin
          if (tm.done) begin
            o_restart_n <= 1'b1;
            o_abort     <= was_busy;
            load        <= 1'b1;
            count       <= 32'(was_busy ? RDYB_CYC : RDYI_CYC);
            st          <= S_RST_WAIT;
          end
        end
        S_RST_WAIT: begin
          if (tm.done && i_ready_busy_n) begin
            load  <= 1'b1;
            count <= 32'(RH_CYC);
            st    <= S_RH;
          end
        end
        S_RH: begin
          if (tm.done) begin
            o_ack <= 1'b1;
            st    <= S_IDLE;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  // Protect/accelerate pin, always at a defined level
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_protect_accel_pin <= FMB_PA_LOW;
    end else if (st == S_IDLE && i_req && i_op == FMB_OP_ACCEL_ON) begin
      o_protect_accel_pin <= FMB_PA_ACCEL;
    end else if (st == S_IDLE && i_req && i_op != FMB_OP_WRITE) begin
      o_protect_accel_pin <= i_wp_on ? FMB_PA_LOW : FMB_PA_HIGH;
    end else if (o_protect_accel_pin != FMB_PA_ACCEL) begin
      o_protect_accel_pin <= i_wp_on ? FMB_PA_LOW : FMB_PA_HIGH;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (st != S_IDLE) || i_req;
    end
  end

  property p_rst_width;
    @(posedge i_clk) disable iff (i_rst)
      $fell(o_restart_n) |-> !o_restart_n [*8];
  endproperty
  a_rst_width: assert property (p_rst_width) else $error("restart pulse short");

  property p_accel_only_write;
    @(posedge i_clk) disable iff (i_rst)
      (o_protect_accel_pin == FMB_PA_ACCEL) |-> o_oe_n;
  endproperty
  a_accel_only_write: assert property (p_accel_only_write) else $error("accel on read");

  property p_defined_pa;
    @(posedge i_clk) disable iff (i_rst)
      o_protect_accel_pin != 2'b11;
  endproperty
  a_defined_pa: assert property (p_defined_pa) else $error("pin level undefined");

  property p_ack_after_restart;
    @(posedge i_clk) disable iff (i_rst)
      (st == S_RST_WAIT && tm.done && i_ready_busy_n) |=> !o_ack [*6];
  endproperty
  a_ack_after_restart: assert property (p_ack_after_restart) else $error("early read");

  property p_read_access;
    @(posedge i_clk) disable iff (i_rst)
      $fell(o_oe_n) |-> !o_oe_n [*7];
  endproperty
  a_read_access: assert property (p_read_access) else $error("short access");

  property p_no_oe_with_we;
    @(posedge i_clk) disable iff (i_rst)
      !o_we_n |-> o_oe_n;
  endproperty
  a_no_oe_with_we: assert property (p_no_oe_with_we) else $error("gate during write");

  property p_byte_top;
    @(posedge i_clk) disable iff (i_rst)
      (!o_width_n && !o_ce_n) |-> o_dq_oe_n[14:8] == 7'h7F;
  endproperty
  a_byte_top: assert property (p_byte_top) else $error("byte lanes driven");

  property p_ready_wait;
    @(posedge i_clk) disable iff (i_rst)
      (st == S_RST_WAIT && !i_ready_busy_n) |=> st == S_RST_WAIT;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("left wait while busy");
endmodule : fmb_host

//--- include/fmb_pkg.sv
/*
  Package for the flash mode and bank host controller: timing counts,
  pin levels and bank geometry.
  Assumes a 100 MHz system clock.
*/
package fmb_pkg;
  localparam int CLK_NS = 10;
  // Timing figures in ns, defaults chosen where not given
  localparam int ADDR_ACCESS_NS      = 70;
  localparam int CE_ACCESS_NS        = 70;
  localparam int RESTART_PULSE_NS    = 500;
  localparam int RESTART_TO_READ_NS  = 50;
  localparam int READY_IDLE_NS       = 500;
  localparam int READY_BUSY_NS       = 20000;
  localparam int SLEEP_EXTRA_NS      = 30;
  localparam int WRITE_PULSE_NS      = 35;
  // Cycle counts: least times round up
  localparam int ACC_CYC   = (ADDR_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CE_CYC    = (CE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC    = (RESTART_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RH_CYC    = (RESTART_TO_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int RDYI_CYC  = (READY_IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RDYB_CYC  = (READY_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC    = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLEEP_CYC = (ADDR_ACCESS_NS + SLEEP_EXTRA_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 12;
  // Protect/accelerate pin levels driven through an external switch
  typedef enum logic [1:0] {FMB_PA_LOW, FMB_PA_HIGH, FMB_PA_ACCEL} fmb_pa_t;
  // Host operations
  typedef enum logic [2:0] {
    FMB_OP_READ, FMB_OP_WRITE, FMB_OP_RESTART, FMB_OP_ACCEL_ON, FMB_OP_ACCEL_OFF
  } fmb_op_t;
  // Bank sizes in Mb by variant: four-bank, two-bank A, two-bank B
  localparam logic [7:0] BANK4_MB [4] = '{8'h04, 8'h0C, 8'h0C, 8'h04};
  localparam logic [7:0] BANK2A_MB [2] = '{8'h04, 8'h1C};
  localparam logic [7:0] BANK2B_MB [2] = '{8'h08, 8'h18};
  localparam logic [5:0] SMALL_SECT_B1 = 6'h08;
  localparam logic [5:0] B4_LAST_SECTS = 6'h08;
  localparam logic [5:0] B2A_LAST_SECTS = 6'h38;
  localparam logic [5:0] B2B_LAST_SECTS = 6'h30;
  localparam logic [5:0] B4_FIRST_BIG = 6'h07;
  localparam logic [5:0] B2A_FIRST_BIG = 6'h07;
  localparam logic [5:0] B2B_FIRST_BIG = 6'h0F;
endpackage : fmb_pkg

//--- include/fmb_tmr_if.sv
/*
  Interface between the sequencer and its cycle timer.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface fmb_tmr_if;
  logic        load;
  logic [31:0] count;
  logic        done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface : fmb_tmr_if

//--- rtl/fmb_timer.sv
/*
  Down counter that flags done once the loaded count of cycles has passed.
  Assumes a load pulse from the sequencer.
*/
`timescale 1ns/1ps
module fmb_timer (
  input  wire logic i_clk,
  input  wire logic i_rst,
  fmb_tmr_if.tmr    t
);
  import fmb_pkg::*;
  logic [31:0] cnt;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 32'h0000_0000;
    end else if (t.load) begin
      cnt <= t.count;
    end else if (cnt != 32'h0000_0000) begin
      cnt <= cnt - 32'h0000_0001;
    end
  end
  assign t.done = (cnt == 32'h0000_0000) && !t.load;
endmodule : fmb_timer

//--- bench/fmb_flash_model.sv
/*
  Behavioural flash partner: small word array, busy timer, restart handling.
  Assumes pins from the host controller; the model counts busy down in its own 10 ns steps.
*/
`timescale 1ns/1ps
module fmb_flash_model (
  input  wire logic            i_restart_n,
  input  wire logic [20:0]     i_addr,
  input  wire logic [15:0]     i_dq,
  input  wire logic            i_ce_n,
  input  wire logic            i_oe_n,
  input  wire logic            i_we_n,
  input  wire logic            i_width_n,
  input  wire fmb_pkg::fmb_pa_t i_pa,
  output logic [15:0]          o_dq,
  output logic                 o_ready_busy_n
);
  import fmb_pkg::*;
  logic [15:0] mem [16];
  logic [15:0] noise = 16'hA5A5;
  logic [15:0] word;
  int          busy = 0;
  initial foreach (mem[i]) mem[i] = 16'h0000;
  always #5 noise = ~noise;
  always #10 if (busy > 0) busy = busy - 1;
  assign o_ready_busy_n = (busy == 0);
  assign word = mem[i_addr[3:0]];
  always @* begin
    if (!i_restart_n || i_ce_n || i_oe_n) o_dq = noise;
    else if (!i_width_n) o_dq = {noise[15:8], i_dq[15] ? word[15:8] : word[7:0]};
    else o_dq = word;
  end
  // Write cycle starts a program; accelerated level shortens it
  always @(posedge i_we_n) if (!i_ce_n && i_restart_n) begin
    mem[i_addr[3:0]] = i_dq;
    busy = (i_pa == FMB_PA_ACCEL) ? 10 : 40;
  end
  always @(negedge i_restart_n) if (busy > 0) busy = 100;
endmodule : fmb_flash_model

//--- bench/fmb_host_bench.sv
/*
  Self-checking bench for the flash host controller against a flash model.
  Assumes the design package, interface, design and model compiled first.
*/
`timescale 1ns/1ps
module fmb_host_bench;
  import fmb_pkg::*;
  typedef struct packed {logic [1:0] kind; logic [15:0] val;} fmb_note_t;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_req = 1'b0;
  logic        i_byte_mode = 1'b0;
  logic        i_wp_on = 1'b1;
  fmb_op_t     i_op = FMB_OP_READ;
  logic [21:0] i_addr = 22'h000000;
  logic [15:0] i_wdata = 16'h0000;
  logic [15:0] m_dq, dq_bus, o_rdata, o_dq_out, o_dq_oe_n, seen, w0, w1;
  logic [20:0] o_addr;
  logic        rb_n, o_ack, o_busy, o_ce_n, o_oe_n, o_we_n, o_restart_n, o_width_n, o_abort;
  logic        abort_seen = 1'b0;
  fmb_pa_t     o_protect_accel_pin;
  fmb_note_t   notes [$];
  fmb_note_t   nt;
  string       nm [3] = '{"rdata", "abort", "accel pin"};
  int          bad_count = 0;
  int          checked = 0;
  logic [31:0] rnd = 32'h0000_0049;
  always #5 i_clk = ~i_clk;
  assign dq_bus = (~o_dq_oe_n & o_dq_out) | (o_dq_oe_n & m_dq);
  fmb_host u_fmb_host (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_op(i_op),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_byte_mode(i_byte_mode), .i_wp_on(i_wp_on),
    .i_dq_in(dq_bus), .i_ready_busy_n(rb_n), .o_ack(o_ack), .o_rdata(o_rdata),
    .o_busy(o_busy), .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe_n(o_dq_oe_n),
    .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_restart_n(o_restart_n),
    .o_width_n(o_width_n), .o_protect_accel_pin(o_protect_accel_pin), .o_abort(o_abort));
  fmb_flash_model u_fmb_flash_model (.i_restart_n(o_restart_n), .i_addr(o_addr),
    .i_dq(dq_bus), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
    .i_width_n(o_width_n), .i_pa(o_protect_accel_pin), .o_dq(m_dq), .o_ready_busy_n(rb_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic summarize();
    if (notes.size() != 0) begin
      bad_count++;
      $display("wrong value pending notes expected 0 seen %0d", notes.size());
    end
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // Note the expectation, then hold the request until acknowledged
  task automatic op(input fmb_op_t o, input logic [21:0] a, input logic [15:0] d,
                    input fmb_note_t n);
    int k;
    notes.push_back(n);
    @(negedge i_clk);
    checked++;
    if (o_busy !== 1'b0 || o_ce_n !== 1'b1) begin
      bad_count++;
      $display("wrong value idle busy,ce_n expected 01 seen %b%b", o_busy, o_ce_n);
    end
    i_op = o;
    i_addr = a;
    i_wdata = d;
    i_req = 1'b1;
    for (k = 0; k < 4000 && o_ack !== 1'b1; k++) @(negedge i_clk);
    checked++;
    if (o_ack !== 1'b1) begin
      bad_count++;
      $display("wrong value ack expected 1 seen %b", o_ack);
    end
    i_req = 1'b0;
  endtask : op
  // Result watcher
  always @(negedge i_clk) begin
    if (o_abort === 1'b1) abort_seen = 1'b1;
    if (o_ack === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      seen = nt.kind == 2'h0 ? o_rdata : nt.kind == 2'h1 ? {15'h0000, abort_seen} :
             {14'h0000, o_protect_accel_pin};
      checked++;
      if (seen !== nt.val) begin
        bad_count++;
        $display("wrong value %s expected %h seen %h", nm[nt.kind], nt.val, seen);
      end
      abort_seen = 1'b0;
    end
  end
  initial begin
    fork
      begin
        repeat (30000) @(posedge i_clk);
        bad_count++;
        summarize();
      end
    join_none
    repeat (20) @(posedge i_clk);
    @(negedge i_clk) i_rst = 1'b0;
    rnd = xs(rnd);
    w0 = rnd[15:0];
    w1 = rnd[31:16];
    op(FMB_OP_WRITE, 22'h000002, w0, '{2'h2, 16'h0000});
    op(FMB_OP_READ, 22'h000002, 16'h0000, '{2'h0, w0});
    op(FMB_OP_ACCEL_ON, 22'h000004, w1, '{2'h2, 16'h0002});
    op(FMB_OP_WRITE, 22'h000006, w1, '{2'h2, 16'h0002});
    op(FMB_OP_ACCEL_OFF, 22'h000004, w1, '{2'h1, 16'h0000});
    op(FMB_OP_WRITE, 22'h000008, w0, '{2'h2, 16'h0000});
    op(FMB_OP_READ, 22'h000006, 16'h0000, '{2'h0, w1});
    i_byte_mode = 1'b1;
    op(FMB_OP_READ, 22'h00000D, 16'h0000, '{2'h0, {8'h00, w1[15:8]}});
    op(FMB_OP_READ, 22'h00000C, 16'h0000, '{2'h0, {8'h00, w1[7:0]}});
    i_byte_mode = 1'b0;
    repeat (60) @(negedge i_clk);
    op(FMB_OP_RESTART, 22'h000000, 16'h0000, '{2'h1, 16'h0000});
    op(FMB_OP_WRITE, 22'h00000A, w1, '{2'h2, 16'h0000});
    op(FMB_OP_RESTART, 22'h000000, 16'h0000, '{2'h1, 16'h0001});
    op(FMB_OP_WRITE, 22'h00000A, w0, '{2'h2, 16'h0000});
    op(FMB_OP_READ, 22'h00000A, 16'h0000, '{2'h0, w0});
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      i_wp_on = rnd[20];
      op(FMB_OP_WRITE, {18'h00000, rnd[19:16]}, rnd[15:0], '{2'h2, 16'(!rnd[20])});
      op(FMB_OP_READ, {18'h00000, rnd[19:16]}, 16'h0000, '{2'h0, rnd[15:0]});
    end
    i_wp_on = 1'b1;
    op(FMB_OP_ACCEL_ON, 22'h000003, w0, '{2'h2, 16'h0002});
    @(negedge i_clk) i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    checked++;
    if (o_protect_accel_pin !== FMB_PA_LOW) begin
      bad_count++;
      $display("wrong value reset pin expected 0 seen %0d", o_protect_accel_pin);
    end
    op(FMB_OP_READ, 22'h000003, 16'h0000, '{2'h0, w0});
    repeat (5) @(negedge i_clk);
    summarize();
  end
endmodule : fmb_host_bench
